// File: cwg_params.svh
`ifndef CWG_PARAMS_SVH
`define CWG_PARAMS_SVH

// register byte addresses on the wishbone bus; ADDR_FALL and ADDR_STATUS alias control 0 and control 1
`define ADDR_CTRL0       4'h0
`define ADDR_CTRL1       4'h4
`define ADDR_CTRL2       4'h8
`define ADDR_RISE        4'hc
`define ADDR_FALL        4'h0
`define ADDR_STATUS      4'h4
// control 0 fields
`define C0_EN            7
`define C0_OEB           6
`define C0_OEA           5
`define C0_POLB          4
`define C0_POLA          3
`define C0_CS            0
// control 1 fields
`define C1_LVLB_HI       7
`define C1_LVLB_LO       6
`define C1_LVLA_HI       5
`define C1_LVLA_LO       4
`define C1_IS_HI         1
`define C1_IS_LO         0
// control 2 fields
`define C2_ASE           7
`define C2_ARS           6
`define C2_SDC2          3
`define C2_SDC1          2
`define C2_SDFLT         1
// reset values
`define CTRL0_RST        8'h00
`define CTRL1_RST        8'h00
`define CTRL2_RST        8'h00
`define DELAY_RST        6'h00
// internal oscillator rate and the enable divider from the 25 MHz system clock
`define MCLK_HZ          25000000
`define FAST_OSC_HZ      16000000
`define OSC_ACC_W        26

`endif

// File: cwg_pkg.sv
package cwg_pkg;

  typedef enum logic [1:0]
  {
    SRC_CMP1 = 2'b00,
    SRC_CMP2 = 2'b01,
    SRC_PWM1 = 2'b10,
    SRC_PWM2 = 2'b11
  } input_source_t;

  typedef enum logic [1:0]
  {
    LVL_INACTIVE = 2'b00,
    LVL_TRISTATE = 2'b01,
    LVL_LOW      = 2'b10,
    LVL_HIGH     = 2'b11
  } shutdown_level_t;

  typedef enum logic [1:0]
  {
    DB_IDLE  = 2'b00,
    DB_RISE  = 2'b01,
    DB_FALL  = 2'b10
  } db_state_t;

  // raw source signals, grouped as they arrive
  typedef struct packed
  {
    logic comparator1_raw_output;
    logic comparator2_raw_output;
    logic pulse_width_unit1_output;
    logic pulse_width_unit2_output;
    logic fault_input_pin;
  } sources_t;

  // two-signal pin bundle; oe low means driven
  typedef struct packed
  {
    logic out;
    logic oe_n;
  } pin_drive_t;

endpackage

// File: complementary_generator.sv
// Functional notes
// - two complementary outputs from one selected input
// - select 11 pwm2, 10 pwm1, 01 cmp2, 00 cmp1
// - one bit picks dead-band clock source
// - select 1 fast oscillator, 0 system clock
// - both drives cleared right after enabling
// - per-output enable; clear releases pin
// - module off means enables have no effect
// - per-output polarity bit, set active high
// - polarity ignored for shutdown override levels except inactive
// - one six-bit counter shared by rising and falling
// - count clock periods from zero to setting
// - rising edge: b off, delay, a on
// - falling edge: a off, delay, b on
// - delay 0 to 63 counts, zero none
// - short input pulse never turns output on
// - delay jitter at most one clock period
// - software shutdown bit forces override levels
// - no auto-restart: shutdown holds while bit set
// - auto-restart clears bit, resumes next rising edge
// - selected external shutdown acts at once
// - each shutdown source has own select bit
// - shutdown level sensitive; holds while active
// - level field 11 high 10 low 01 float 00 inactive
// - keeps running off its own clock in sleep
// - fast oscillator kept running when in use
`timescale 1ns/1ns
`include "cwg_params.svh"

module complementary_generator
  import cwg_pkg::*;
(
  input  wire logic                 MCLK,            // 25 MHz system clock
  input  wire logic                 RST,             // asynchronous reset, active high
  input  wire logic                 WB_CYC_I,        // wishbone cycle
  input  wire logic                 WB_STB_I,        // wishbone strobe
  input  wire logic                 WB_WE_I,         // wishbone write enable
  input  wire logic [3:0]           WB_ADR_I,        // wishbone byte address
  input  wire logic [3:0]           WB_SEL_I,        // wishbone byte lanes
  input  wire logic [31:0]          WB_DAT_I,        // wishbone write data
  output logic      [31:0]          WB_DAT_O,        // wishbone read data
  output logic                      WB_ACK_O,        // wishbone acknowledge
  input  wire cwg_pkg::sources_t    SRC_IN,          // selectable and shutdown sources
  output cwg_pkg::pin_drive_t       OUTPUT_A,        // pin a drive and enable
  output cwg_pkg::pin_drive_t       OUTPUT_B,        // pin b drive and enable
  output logic                      FAST_OSC_KEEP    // request to keep the fast oscillator running
);
  import cwg_pkg::*;

  // register state
  logic [7:0] ctrl0_ff, nxt_ctrl0;
  logic [7:0] ctrl1_ff, nxt_ctrl1;
  logic [7:0] ctrl2_ff, nxt_ctrl2;
  logic [5:0] rise_ff, nxt_rise;
  logic [5:0] fall_ff, nxt_fall;
  logic       ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;

  // dead-band state
  db_state_t  db_ff, nxt_db;
  logic [5:0] cnt_ff, nxt_cnt;
  logic       a_ff, nxt_a;
  logic       b_ff, nxt_b;
  logic       in_d_ff, nxt_in_d;
  logic       en_d_ff, nxt_en_d;
  logic       hold_ff, nxt_hold;
  logic [`OSC_ACC_W-1:0] acc_ff, nxt_acc;
  logic       tick_ff, nxt_tick;
  pin_drive_t pa_ff, nxt_pa;
  pin_drive_t pb_ff, nxt_pb;
  logic       keep_ff, nxt_keep;

  // decoded control, one signal a line
  logic       in_sel;      // selected waveform input
  logic       ext_sd;      // any selected shutdown source active
  logic       tick;        // dead-band count enable
  logic       module_on;   // module enable bit
  logic       rise_ev;     // rising edge of the selected input
  logic       fall_ev;     // falling edge of the selected input
  logic       req;         // bus request taken this edge
  logic       wr;          // write to lane 0 taken this edge

  // override level for one pin; polarity only applies in the inactive code
  function automatic pin_drive_t override_pin(input logic [1:0] lvl, input logic pol);
    pin_drive_t p;
    p.out  = 1'b0;
    p.oe_n = 1'b0;
    // tri-state leaves out low so a floating pin carries no stale level
    unique case (shutdown_level_t'(lvl))
      LVL_HIGH:     p.out = 1'b1;
      LVL_LOW:      p.out = 1'b0;
      LVL_TRISTATE: p.oe_n = 1'b1;
      LVL_INACTIVE: p.out = ~pol;
    endcase
    return p;
  endfunction

  // normal drive for one pin: enable gated by the module bit
  function automatic pin_drive_t normal_pin(input logic act, input logic pol, input logic oe, input logic on);
    pin_drive_t p;
    p.out  = pol ? act : ~act;
    p.oe_n = ~(oe & on);
    // a released pin shows a quiet low so nothing stale leaks out
    if (p.oe_n)
      p.out = 1'b0;
    return p;
  endfunction

  // word index of a byte address; the low two bits are dropped and byte lanes come from WB_SEL_I
  function automatic logic [1:0] word_of(input logic [3:0] adr);
    return adr[3:2];
  endfunction

  // input mux and shutdown sources
  always_comb
  begin
    // four-way source pick; every code is legal, so no default
    unique case (input_source_t'(ctrl1_ff[`C1_IS_HI:`C1_IS_LO]))
      SRC_CMP1: in_sel = SRC_IN.comparator1_raw_output;
      SRC_CMP2: in_sel = SRC_IN.comparator2_raw_output;
      SRC_PWM1: in_sel = SRC_IN.pulse_width_unit1_output;
      SRC_PWM2: in_sel = SRC_IN.pulse_width_unit2_output;
    endcase
    // any mix of shutdown sources, each gated by its own select bit
    ext_sd = (ctrl2_ff[`C2_SDC1] & SRC_IN.comparator1_raw_output) |
             (ctrl2_ff[`C2_SDC2] & SRC_IN.comparator2_raw_output) |
             (ctrl2_ff[`C2_SDFLT] & SRC_IN.fault_input_pin);
    module_on = ctrl0_ff[`C0_EN];
    // the system clock counts every cycle; the fast source is a fractional enable
    tick = ctrl0_ff[`C0_CS] ? tick_ff : 1'b1;
    // edge detect against last cycle's level; history resets to the idle low
    rise_ev = in_sel & ~in_d_ff;
    fall_ev = ~in_sel & in_d_ff;
    // a request is taken once; the pending ack blocks a second take
    req = WB_CYC_I & WB_STB_I & ~ack_ff;
    wr  = req & WB_WE_I & WB_SEL_I[0];
  end

  // 16 MHz tick from the 25 MHz clock by phase accumulation; jitter is one period
  always_comb
  begin
    // the long-run rate is exact; single ticks land up to one system period off
    // the sum stays below twice the system rate, so the width is ample
    nxt_acc  = acc_ff + `OSC_ACC_W'(`FAST_OSC_HZ);
    nxt_tick = 1'b0;
    if (nxt_acc >= `OSC_ACC_W'(`MCLK_HZ))
    begin
      nxt_acc  = nxt_acc - `OSC_ACC_W'(`MCLK_HZ);
      nxt_tick = 1'b1;
    end
  end

  // register file and shutdown status
  always_comb
  begin
    nxt_ctrl0 = ctrl0_ff;
    nxt_ctrl1 = ctrl1_ff;
    nxt_ctrl2 = ctrl2_ff;
    nxt_rise  = rise_ff;
    nxt_fall  = fall_ff;
    nxt_ack   = req;
    nxt_rdat  = 32'h0;
    // writes need byte lane 0; reserved bits are masked so they read back as zero
    if (wr)
    begin
      unique case (word_of(WB_ADR_I))
        2'b00: nxt_ctrl0 = WB_DAT_I[7:0] & 8'hf9;
        2'b01: nxt_ctrl1 = WB_DAT_I[7:0] & 8'hf3;
        2'b10: nxt_ctrl2 = WB_DAT_I[7:0] & 8'hce;
        2'b11: ;
      endcase
      // both delays share one word: rising in the low byte, falling in the next
      if (word_of(WB_ADR_I) == 2'b11)
      begin
        nxt_rise = WB_DAT_I[5:0];
        nxt_fall = WB_DAT_I[13:8];
      end
    end
    // read data stands for the ack cycle only and is zero otherwise
    if (req && !WB_WE_I)
    begin
      unique case (word_of(WB_ADR_I))
        2'b00: nxt_rdat = {24'h0, ctrl0_ff};
        2'b01: nxt_rdat = {24'h0, ctrl1_ff};
        2'b10: nxt_rdat = {24'h0, ctrl2_ff};
        2'b11: nxt_rdat = {18'h0, fall_ff, 2'h0, rise_ff};
      endcase
    end
    // external source sets the status bit; set wins over a software clear
    if (ext_sd)
    begin
      nxt_ctrl2[`C2_ASE] = 1'b1;
    end
    // auto-restart clears the bit once every selected source is low
    else if (ctrl2_ff[`C2_ARS] && ctrl2_ff[`C2_ASE])
      nxt_ctrl2[`C2_ASE] = 1'b0;
  end

  // dead-band sequencer
  always_comb
  begin
    nxt_db   = db_ff;
    nxt_cnt  = cnt_ff;
    nxt_a    = a_ff;
    nxt_b    = b_ff;
    nxt_in_d = in_sel;
    nxt_en_d = module_on;
    nxt_hold = hold_ff;
    // overrides stay until the first rising input edge after the status clears
    if (ctrl2_ff[`C2_ASE] || ext_sd)
      nxt_hold = 1'b1;
    else if (rise_ev)
      nxt_hold = 1'b0;                  // resume at next rising edge
    // module off or just switched on: both drives start cleared
    if (!module_on || (module_on && !en_d_ff))
    begin
      nxt_a  = 1'b0;
      nxt_b  = 1'b0;
      nxt_db = DB_IDLE;
    end
    else if (rise_ev)
    begin
      // b drops at once, a waits out the rising dead band
      nxt_b   = 1'b0;
      nxt_cnt = 6'h00;
      nxt_db  = DB_RISE;
    end
    else if (fall_ev)
    begin
      // a drops at once, b waits out the falling dead band
      nxt_a   = 1'b0;
      nxt_cnt = 6'h00;
      nxt_db  = DB_FALL;
    end
    else
    begin
      // any new edge restarts the count, so a short pulse never turns an output on
      unique case (db_ff)
        DB_IDLE: ;
        DB_RISE:
          if (cnt_ff >= rise_ff)
          begin
            nxt_a  = 1'b1;
            nxt_db = DB_IDLE;
          end
          else if (tick)
            nxt_cnt = cnt_ff + 6'h01;
        DB_FALL:
          if (cnt_ff >= fall_ff)
          begin
            nxt_b  = 1'b1;
            nxt_db = DB_IDLE;
          end
          else if (tick)
            nxt_cnt = cnt_ff + 6'h01;
        default: nxt_db = DB_IDLE;
      endcase
    end
  end

  // pin drive: override in shutdown, waveform otherwise
  always_comb
  begin
    // external sources act straight from the pins so the override is one edge away
    if (hold_ff || ext_sd)
    begin
      nxt_pa = override_pin(ctrl1_ff[`C1_LVLA_HI:`C1_LVLA_LO], ctrl0_ff[`C0_POLA]);
      nxt_pb = override_pin(ctrl1_ff[`C1_LVLB_HI:`C1_LVLB_LO], ctrl0_ff[`C0_POLB]);
      // a disabled pin or a switched-off module releases the pin in shutdown too
      if (!(ctrl0_ff[`C0_OEA] && module_on))
        nxt_pa = '{out: 1'b0, oe_n: 1'b1};
      if (!(ctrl0_ff[`C0_OEB] && module_on))
        nxt_pb = '{out: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      nxt_pa = normal_pin(a_ff, ctrl0_ff[`C0_POLA], ctrl0_ff[`C0_OEA], module_on);
      nxt_pb = normal_pin(b_ff, ctrl0_ff[`C0_POLB], ctrl0_ff[`C0_OEB], module_on);
    end
    // oscillator request follows module enable and clock select only
    nxt_keep = module_on & ctrl0_ff[`C0_CS];
  end

  // state registers
  // reset releases both pins, so nothing is driven until software enables them
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl0_ff <= `CTRL0_RST;
      ctrl1_ff <= `CTRL1_RST;
      ctrl2_ff <= `CTRL2_RST;
      rise_ff  <= `DELAY_RST;
      fall_ff  <= `DELAY_RST;
      ack_ff   <= 1'b0;
      rdat_ff  <= 32'h0;
      db_ff    <= DB_IDLE;
      cnt_ff   <= 6'h00;
      a_ff     <= 1'b0;
      b_ff     <= 1'b0;
      in_d_ff  <= 1'b0;
      en_d_ff  <= 1'b0;
      hold_ff  <= 1'b0;
      acc_ff   <= '0;
      tick_ff  <= 1'b0;
      pa_ff    <= '{out: 1'b0, oe_n: 1'b1};
      pb_ff    <= '{out: 1'b0, oe_n: 1'b1};
      keep_ff  <= 1'b0;
    end
    else
    begin
      ctrl0_ff <= nxt_ctrl0;
      ctrl1_ff <= nxt_ctrl1;
      ctrl2_ff <= nxt_ctrl2;
      rise_ff  <= nxt_rise;
      fall_ff  <= nxt_fall;
      ack_ff   <= nxt_ack;
      rdat_ff  <= nxt_rdat;
      db_ff    <= nxt_db;
      cnt_ff   <= nxt_cnt;
      a_ff     <= nxt_a;
      b_ff     <= nxt_b;
      in_d_ff  <= nxt_in_d;
      en_d_ff  <= nxt_en_d;
      hold_ff  <= nxt_hold;
      acc_ff   <= nxt_acc;
      tick_ff  <= nxt_tick;
      pa_ff    <= nxt_pa;
      pb_ff    <= nxt_pb;
      keep_ff  <= nxt_keep;
    end
  end

  // every output comes straight from a flip-flop
  assign WB_DAT_O      = rdat_ff;
  assign WB_ACK_O      = ack_ff;
  assign OUTPUT_A      = pa_ff;
  assign OUTPUT_B      = pb_ff;
  assign FAST_OSC_KEEP = keep_ff;

endmodule // complementary_generator

// File: complementary_generator_asserts.sv
`timescale 1ns/1ns
module complementary_generator_asserts
  import cwg_pkg::*;
(
  input wire logic               MCLK,          // system clock
  input wire logic               RST,           // async reset
  input wire logic               WB_CYC_I,      // bus cycle
  input wire logic               WB_STB_I,      // bus strobe
  input wire logic               WB_WE_I,       // bus write
  input wire logic [3:0]         WB_ADR_I,      // bus address
  input wire logic [3:0]         WB_SEL_I,      // byte lanes
  input wire logic [31:0]        WB_DAT_I,      // write data
  input wire logic [31:0]        WB_DAT_O,      // read data
  input wire logic               WB_ACK_O,      // acknowledge
  input wire cwg_pkg::sources_t  SRC_IN,        // sources
  input wire cwg_pkg::pin_drive_t OUTPUT_A,     // pin a
  input wire cwg_pkg::pin_drive_t OUTPUT_B,     // pin b
  input wire logic               FAST_OSC_KEEP  // oscillator request
);
  logic [7:0] c0_ff, c1_ff, c2_ff, nxt_c0, nxt_c1, nxt_c2;
  logic       sel_in, run, flt_act;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // shadow of written values only; hardware moves the status bit, so it is not trusted here
  always_comb
  begin
    {nxt_c0, nxt_c1, nxt_c2} = {c0_ff, c1_ff, c2_ff};
    if (WB_ACK_O && WB_WE_I && WB_SEL_I[0])
      case (WB_ADR_I[3:2])
        2'h0: nxt_c0 = WB_DAT_I[7:0];
        2'h1: nxt_c1 = WB_DAT_I[7:0];
        2'h2: nxt_c2 = WB_DAT_I[7:0];
        default: ;
      endcase
  end
  always_ff @(posedge MCLK or posedge RST)
    if (RST) {c0_ff, c1_ff, c2_ff} <= '0;
    else {c0_ff, c1_ff, c2_ff} <= {nxt_c0, nxt_c1, nxt_c2};
  // selected input and the conditions under which the plain waveform is expected
  assign sel_in  = SRC_IN[3'd4 - {1'b0, c1_ff[1:0]}];
  assign run     = c0_ff[7] && c0_ff[6] && (c2_ff[7:1] == 7'h00);
  assign flt_act = ((c2_ff[1] && SRC_IN.fault_input_pin) || (c2_ff[2] && SRC_IN.comparator1_raw_output)
                 || (c2_ff[3] && SRC_IN.comparator2_raw_output)) && c0_ff[7] && c0_ff[5] && (c1_ff[5:4] == 2'b11);
  sequence s_fault_held;
    flt_act [*3];
  endsequence
  sequence s_read_status;
    WB_ACK_O && !WB_WE_I && (WB_ADR_I[3:2] == 2'h2);
  endsequence
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  a_pin_a_free: assert property ((!c0_ff[7] || !c0_ff[5]) [*2] |-> OUTPUT_A.oe_n)
    else $error("pin a driven while off");
  a_pin_b_free: assert property ((!c0_ff[7] || !c0_ff[6]) [*2] |-> OUTPUT_B.oe_n)
    else $error("pin b driven while off");
  a_b_drops_fast: assert property ($rose(sel_in) && run |-> ##[1:4] (OUTPUT_B.out != c0_ff[4]))
    else $error("pin b not turned off");
  a_ext_override: assert property (s_fault_held |-> (OUTPUT_A == 2'b10))
    else $error("override missing");
  a_status_held: assert property (s_fault_held ##0 s_read_status |-> WB_DAT_O[7])
    else $error("status dropped");
  a_osc_kept: assert property ((c0_ff[7] && c0_ff[0]) [*2] |-> FAST_OSC_KEEP)
    else $error("oscillator not kept");
  a_osc_free: assert property (!(c0_ff[7] && c0_ff[0]) [*2] |-> !FAST_OSC_KEEP)
    else $error("oscillator kept");
endmodule // complementary_generator_asserts

bind complementary_generator complementary_generator_asserts chk_u (.MCLK(MCLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SRC_IN(SRC_IN), .OUTPUT_A(OUTPUT_A), .OUTPUT_B(OUTPUT_B),
  .FAST_OSC_KEEP(FAST_OSC_KEEP));

// File: gate_driver_model.sv
`timescale 1ns/1ns
module gate_driver_model
  import cwg_pkg::*;
(
  input  wire logic                clk,      // sampling clock
  input  wire cwg_pkg::pin_drive_t pin_a,    // pin a
  input  wire cwg_pkg::pin_drive_t pin_b,    // pin b
  output int                       overlap   // cycles with both switches on
);
  logic gate_a, gate_b;
  // a released pin is pulled low at the driver input
  assign gate_a = !pin_a.oe_n && pin_a.out;
  assign gate_b = !pin_b.oe_n && pin_b.out;
  // shoot-through shows as both gates on in one cycle; one process owns the count
  initial
  begin
    overlap = 0;
    forever
    begin
      @(posedge clk);
      if (gate_a && gate_b)
        overlap <= overlap + 1;
    end
  end
endmodule // gate_driver_model

// File: complementary_generator_tb_top.sv
`timescale 1ns/1ns
module complementary_generator_tb_top;
  import cwg_pkg::*;
  logic        mclk, rst, cyc, stb, we, ack, keep;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, d;
  sources_t    src;
  pin_drive_t  pa, pb;
  int          num_errors, cmp_count, overlap, n, i;
  logic [7:0]  sdb [3] = '{8'h04, 8'h08, 8'h02};
  logic [4:0]  sdp [3] = '{5'h10, 5'h08, 5'h01};
  complementary_generator dut_u (.MCLK(mclk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SRC_IN(src),
    .OUTPUT_A(pa), .OUTPUT_B(pb), .FAST_OSC_KEEP(keep));
  gate_driver_model drv_u (.clk(mclk), .pin_a(pa), .pin_b(pb), .overlap(overlap));
  initial
  begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  task wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    int t;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, v, 4'hf};
    t = 0;
    do
    begin
      @(posedge mclk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) num_errors++;
    d = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_pin(input string nm, input pin_drive_t e, input pin_drive_t g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s exp %b got %b", nm, e, g);
    end
  endtask
  // bounded wait for a pin level; n ends at 40 if it never comes
  task wait_pin(input logic ab, input logic v);
    n = 0;
    while ((ab ? pa.out : pb.out) !== v && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog sized well above the whole sequence
  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish;
  end
  initial
  begin
    {cyc, stb, we, adr, sel, wdat, src, rst, num_errors, cmp_count} = '0;
    rst = 1;
    repeat (5) @(posedge mclk);
    rst <= 0;
    for (i = 0; i < 4; i++)
    begin
      wb(0, 4'(i * 4), 0);
      chk_reg("reset reg", 0, d);
    end
    wb(1, 4'h0, 32'h60);
    repeat (3) @(posedge mclk);
    chk_pin("pin b off", 2'b01, pb);
    wb(1, 4'h0, 32'hf8);
    repeat (2) @(posedge mclk);
    chk_pin("a after enable", 2'b00, pa);
    // every source code, no dead band
    for (i = 0; i < 4; i++)
    begin
      wb(1, 4'h4, 32'(i));
      src <= 5'h10 >> i;
      wait_pin(1, 1);
      chk_reg("a rise time", 1, n <= 5);
      chk_reg("b off", 0, pb.out);
      src <= 0;
      wait_pin(0, 1);
      chk_reg("b rise time", 1, n <= 5);
      chk_reg("a off", 0, pa.out);
    end
    // dead band 5 rising, 3 falling, counted from the input edge; pwm1 drives the input again
    wb(1, 4'hc, 32'h305);
    wb(0, 4'hc, 0);
    chk_reg("delay word", 32'h305, d);
    wb(1, 4'h4, 32'h2);
    src <= 5'h04;
    repeat (3) @(posedge mclk);
    chk_reg("b quick off", 0, pb.out);
    chk_reg("a held off", 0, pa.out);
    wait_pin(1, 1);
    chk_reg("rise dead band", 1, n >= 4 && n <= 6);
    src <= 0;
    wait_pin(0, 1);
    chk_reg("fall dead band", 1, n >= 5 && n <= 7);
    chk_reg("overlap", 0, overlap);
    wb(1, 4'hc, 32'h308);
    src <= 5'h04;
    repeat (3) @(posedge mclk);
    src <= 0;
    wait_pin(1, 1);
    chk_reg("short pulse", 40, n);
    wb(1, 4'h0, 32'he0);
    repeat (4) @(posedge mclk);
    chk_pin("b active low", 2'b00, pb);
    chk_pin("a inactive high", 2'b10, pa);
    // software shutdown: high and low levels ignore polarity
    wb(1, 4'h4, 32'hb2);
    wb(1, 4'h8, 32'h80);
    src <= 5'h04;
    repeat (4) @(posedge mclk);
    chk_pin("a forced", 2'b10, pa);
    chk_pin("b forced", 2'b00, pb);
    wb(1, 4'h4, 32'h12);
    repeat (3) @(posedge mclk);
    chk_pin("a floated", 2'b01, pa);
    chk_pin("b inactive", 2'b10, pb);
    wb(0, 4'h8, 0);
    chk_reg("status kept", 32'h80, d);
    src <= 0;
    wb(1, 4'h4, 32'hb2);
    // each external source on its own
    for (i = 0; i < 3; i++)
    begin
      src <= sdp[i];
      wb(1, 4'h8, 32'(sdb[i]));
      repeat (3) @(posedge mclk);
      chk_pin("ext override", 2'b10, pa);
      wb(1, 4'h8, 32'(sdb[i]));
      wb(0, 4'h8, 0);
      chk_reg("status held", 32'(sdb[i] | 8'h80), d);
      src <= 0;
      wb(1, 4'h8, 32'(sdb[i]));
      wb(0, 4'h8, 0);
      chk_reg("status cleared", 32'(sdb[i]), d);
    end
    // automatic restart waits for the next rising input edge
    wb(1, 4'h4, 32'h72);
    src <= 5'h01;
    wb(1, 4'h8, 32'h42);
    repeat (3) @(posedge mclk);
    chk_pin("b floated", 2'b01, pb);
    src <= 0;
    repeat (3) @(posedge mclk);
    wb(0, 4'h8, 0);
    chk_reg("auto cleared", 32'h42, d);
    chk_pin("held to edge", 2'b01, pb);
    src <= 5'h04;
    repeat (5) @(posedge mclk);
    chk_pin("b resumed", 2'b10, pb);
    // fast oscillator clock stretches the count by 25/16
    src <= 0;
    wb(1, 4'h8, 0);
    wb(1, 4'h0, 32'he1);
    repeat (3) @(posedge mclk);
    chk_reg("osc kept", 1, keep);
    src <= 5'h04;
    wait_pin(1, 0);
    chk_reg("slow dead band", 1, n >= 14 && n <= 18);
    wb(1, 4'h0, 32'he0);
    repeat (3) @(posedge mclk);
    chk_reg("osc released", 0, keep);
    tally_and_finish;
  end
endmodule // complementary_generator_tb_top
